// *** anp_defines.svh ***
/*
 holds register offsets, field positions, reset values and the register access
 shape for the next-page register bank; assumes 5-bit register addresses and
 16-bit register words.
*/
`ifndef ANP_DEFINES_SVH
`define ANP_DEFINES_SVH

`define ANP_OFS_EXPANSION      5'h06
`define ANP_OFS_NP_TRANSMIT    5'h07
`define ANP_OFS_PARTNER_NP     5'h08

`define ANP_EXP_PD_FAULT_BIT   4
`define ANP_EXP_LP_NP_BIT      3
`define ANP_EXP_LOCAL_NP_BIT   2
`define ANP_EXP_PAGE_RX_BIT    1
`define ANP_EXP_LP_AN_BIT      0

`define ANP_NP_NEXT_BIT        15
`define ANP_NP_MSG_BIT         13
`define ANP_NP_ACK2_BIT        12
`define ANP_NP_TOGGLE_BIT      11
`define ANP_CODE_W             11

`define ANP_EXP_RESET          16'h0004
`define ANP_NPTX_RESET         16'h2001
`define ANP_CODE_RESET         11'h001
`define ANP_NPTX_WMASK         16'hb7ff
`define ANP_PNP_MASK           16'hbfff

`endif

// *** anp_pkg.sv ***
/*
 holds the state type of the next-page register bank; assumes the defines
 header is compiled alongside.
*/
`default_nettype none

package anp_pkg;

   typedef struct packed {
      logic        pd_fault;
      logic        page_rx;
      logic [15:0] np_tx;
      logic [15:0] partner_np;
      logic [15:0] rd_data;
   } anp_state_t;

endpackage

`default_nettype wire

// *** anp_regs.sv ***
/*
 next-page register bank of a 10/100 phy: expansion, next-page transmit and
 link-partner next-page registers; assumes a management-frame decoder on the
 same clock gives one-cycle read/write strobes and the negotiation engine gives
 one-cycle event pulses and levels on the same clock; the engine's toggle level
 is expected to reset to zero with it, as nothing here stores the toggle bit.
*/
`default_nettype none

`include "anp_defines.svh"

// Overview of operation
// - fault and page-received latch high until read
// - local next-page capability always reads one
// - partner next-page capable bit follows partner
// - eleven-bit code field writable, resets to 001
// - toggle bit is not stored, reads engine's toggle level
// - partner next page captured, read-only, resets zero
module anp_regs
   import anp_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic [4:0]  reg_addr_in,
   input  wire logic        reg_wr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_rd_in,
   output logic      [15:0] reg_rdata_out,
   input  wire logic        pd_fault_evt_in,
   input  wire logic        page_rx_evt_in,
   input  wire logic        lp_np_able_in,
   input  wire logic        lp_an_able_in,
   input  wire logic        toggle_in,
   input  wire logic        partner_np_load_in,
   input  wire logic [15:0] partner_np_in,
   output logic      [15:0] np_tx_out
);

   anp_state_t state_reg;
   anp_state_t state_next;
   logic       rd_exp;
   logic [15:0] exp_view;
   logic [15:0] np_view;

   assign rd_exp = reg_rd_in && (reg_addr_in == `ANP_OFS_EXPANSION);

   // partner ability bits are live levels sampled at the read edge, not latched
   always_comb
   begin
      exp_view = 16'h0000;
      exp_view[`ANP_EXP_PD_FAULT_BIT] = state_reg.pd_fault;
      exp_view[`ANP_EXP_LP_NP_BIT]    = lp_np_able_in;
      exp_view[`ANP_EXP_LOCAL_NP_BIT] = 1'b1;
      exp_view[`ANP_EXP_PAGE_RX_BIT]  = state_reg.page_rx;
      exp_view[`ANP_EXP_LP_AN_BIT]    = lp_an_able_in;
      // the stored toggle bit stays zero; the engine's level replaces it so the bus
      // view and the page on its way out never disagree
      np_view = state_reg.np_tx;
      np_view[`ANP_NP_TOGGLE_BIT] = toggle_in;
   end

   always_comb
   begin
      state_next = state_reg;
      // a read clears the latched flag, but an event in the same cycle wins
      if (rd_exp)
      begin
         state_next.pd_fault = 1'b0;
         state_next.page_rx  = 1'b0;
      end
      if (pd_fault_evt_in)
         state_next.pd_fault = 1'b1;
      if (page_rx_evt_in)
         state_next.page_rx = 1'b1;
      // reserved bit 14 and the toggle bit are not writable
      if (reg_wr_in && (reg_addr_in == `ANP_OFS_NP_TRANSMIT))
         state_next.np_tx = reg_wdata_in & `ANP_NPTX_WMASK;
      // reserved bit 14 of the captured page always reads zero
      if (partner_np_load_in)
         state_next.partner_np = partner_np_in & `ANP_PNP_MASK;
      // read data is registered and stands until the next read
      state_next.rd_data = 16'h0000;
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            `ANP_OFS_EXPANSION:   state_next.rd_data = exp_view;
            `ANP_OFS_NP_TRANSMIT: state_next.rd_data = np_view;
            `ANP_OFS_PARTNER_NP:  state_next.rd_data = state_reg.partner_np;
            default:              state_next.rd_data = 16'h0000;
         endcase
      end
      else
         state_next.rd_data = state_reg.rd_data;
      // reset comes last so it overrides an event or a write in the same cycle
      if (srst_in)
      begin
         state_next.pd_fault   = 1'b0;
         state_next.page_rx    = 1'b0;
         state_next.np_tx      = `ANP_NPTX_RESET;
         state_next.partner_np = 16'h0000;
         state_next.rd_data    = 16'h0000;
      end
   end

   // every register of the bank lives in the one state word
   always_ff @(posedge clk_in)
   begin
      state_reg <= state_next;
   end

   assign reg_rdata_out = state_reg.rd_data;
   assign np_tx_out     = np_view;

   // latched flags: set by the event, cleared by a read, the event winning a tie
   flag_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
      pd_fault_evt_in |=> state_reg.pd_fault)
      else $error("fault flag not latched");

   page_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
      page_rx_evt_in |=> state_reg.page_rx)
      else $error("page flag not latched");

   flag_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
      rd_exp && !page_rx_evt_in |=> !state_reg.page_rx)
      else $error("page flag not cleared by read");

   fault_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
      rd_exp && !pd_fault_evt_in |=> !state_reg.pd_fault)
      else $error("fault flag not cleared by read");

   flag_stick_a: assert property (@(posedge clk_in) disable iff (srst_in)
      state_reg.page_rx && !$past(rd_exp) |-> $past(state_reg.page_rx) || $past(page_rx_evt_in))
      else $error("page flag set without event");

   fault_stick_a: assert property (@(posedge clk_in) disable iff (srst_in)
      state_reg.pd_fault && !$past(rd_exp)
      |-> $past(state_reg.pd_fault) || $past(pd_fault_evt_in))
      else $error("fault flag set without event");

   flag_read_a: assert property (@(posedge clk_in) disable iff (srst_in)
      rd_exp |=> reg_rdata_out[`ANP_EXP_PD_FAULT_BIT] == $past(state_reg.pd_fault)
      && reg_rdata_out[`ANP_EXP_PAGE_RX_BIT] == $past(state_reg.page_rx))
      else $error("latched flags not shown on read");

   // expansion word: fixed one, live partner ability, reserved zeros
   local_np_a: assert property (@(posedge clk_in) disable iff (srst_in)
      rd_exp |=> reg_rdata_out[`ANP_EXP_LOCAL_NP_BIT])
      else $error("local next page bit not one");

   lp_np_a: assert property (@(posedge clk_in) disable iff (srst_in)
      rd_exp |=> reg_rdata_out[`ANP_EXP_LP_NP_BIT] == $past(lp_np_able_in))
      else $error("partner next page bit wrong");

   exp_rsvd_a: assert property (@(posedge clk_in) disable iff (srst_in)
      rd_exp |=> reg_rdata_out[15:5] == 11'h000)
      else $error("expansion reserved bits not zero");

   // transmit page: written fields land, the rest holds, toggle comes from the engine
   code_wr_a: assert property (@(posedge clk_in) disable iff (srst_in)
      reg_wr_in && reg_addr_in == `ANP_OFS_NP_TRANSMIT
      |=> np_tx_out[10:0] == $past(reg_wdata_in[10:0]))
      else $error("code field not written");

   code_rst_a: assert property (@(posedge clk_in)
      srst_in |=> np_tx_out[10:0] == `ANP_CODE_RESET && !np_tx_out[`ANP_NP_ACK2_BIT])
      else $error("code field reset wrong");

   np_ctl_wr_a: assert property (@(posedge clk_in) disable iff (srst_in)
      reg_wr_in && reg_addr_in == `ANP_OFS_NP_TRANSMIT
      |=> np_tx_out[`ANP_NP_NEXT_BIT] == $past(reg_wdata_in[`ANP_NP_NEXT_BIT])
      && np_tx_out[`ANP_NP_MSG_BIT] == $past(reg_wdata_in[`ANP_NP_MSG_BIT])
      && np_tx_out[`ANP_NP_ACK2_BIT] == $past(reg_wdata_in[`ANP_NP_ACK2_BIT]))
      else $error("control bits not written");

   np_keep_a: assert property (@(posedge clk_in) disable iff (srst_in)
      !(reg_wr_in && reg_addr_in == `ANP_OFS_NP_TRANSMIT)
      |=> $stable(state_reg.np_tx))
      else $error("transmit page changed without write");

   np_rd_a: assert property (@(posedge clk_in) disable iff (srst_in)
      reg_rd_in && reg_addr_in == `ANP_OFS_NP_TRANSMIT
      |=> reg_rdata_out == $past(np_tx_out))
      else $error("transmit page read wrong");

   toggle_a: assert property (@(posedge clk_in) disable iff (srst_in)
      reg_rd_in && reg_addr_in == `ANP_OFS_NP_TRANSMIT
      |=> reg_rdata_out[`ANP_NP_TOGGLE_BIT] == $past(toggle_in))
      else $error("toggle not tracked");

   // partner page: loaded only by the capture strobe, never by the bus
   partner_a: assert property (@(posedge clk_in) disable iff (srst_in)
      partner_np_load_in ##1 (reg_rd_in && reg_addr_in == `ANP_OFS_PARTNER_NP && !partner_np_load_in)
      |=> reg_rdata_out == ($past(partner_np_in, 2) & `ANP_PNP_MASK))
      else $error("partner page not captured");

   partner_ro_a: assert property (@(posedge clk_in) disable iff (srst_in)
      !partner_np_load_in |=> $stable(state_reg.partner_np))
      else $error("partner page changed without capture");

   partner_rd_a: assert property (@(posedge clk_in) disable iff (srst_in)
      reg_rd_in && reg_addr_in == `ANP_OFS_PARTNER_NP
      |=> reg_rdata_out == $past(state_reg.partner_np))
      else $error("partner page read wrong");

   partner_rst_a: assert property (@(posedge clk_in)
      srst_in
      |=> state_reg.partner_np == 16'h0000 && !state_reg.pd_fault && !state_reg.page_rx)
      else $error("partner page or flags not reset");

   // read port: data stands until the next read, unmapped reads give zero
   rd_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without read");

   unmapped_rd_a: assert property (@(posedge clk_in) disable iff (srst_in)
      reg_rd_in && reg_addr_in != `ANP_OFS_EXPANSION && reg_addr_in != `ANP_OFS_NP_TRANSMIT
      && reg_addr_in != `ANP_OFS_PARTNER_NP |=> reg_rdata_out == 16'h0000)
      else $error("unmapped read not zero");

endmodule // anp_regs

`default_nettype wire

// *** anp_sta_model.sv ***
/* station manager model: register reads and writes.
   assumes strobes are taken at a rising edge, read data one cycle later. */
`default_nettype none
module anp_sta_model (
   input  wire logic        clk_in,
   input  wire logic [15:0] rdata_in,
   output var  logic [4:0]  addr_out,
   output var  logic        wr_out,
   output var  logic        rd_out,
   output var  logic [15:0] wdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {addr_out, wr_out, rd_out, wdata_out} = '0;
   end
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk_in);
      {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
      @(negedge clk_in);
      // stale data is inverted so a late sample cannot match
      {wr_out, wdata_out} = {1'b0, ~d};
   endtask
   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      @(negedge clk_in);
      {addr_out, rd_out} = {a, 1'b1};
      @(negedge clk_in);
      rd_out = 1'b0;
      d = rdata_in;
   endtask
endmodule // anp_sta_model
`default_nettype wire

// *** anp_regs_tb.sv ***
/* bench for the next-page register bank.
   assumes the station model drives the register strobes. */
`default_nettype none
module anp_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_in, srst_in, pd, prx, lpnp, lpan, tog, ld, wr, rd;
   logic [15:0] pnp, rdata, nptx, wd;
   logic [4:0]  addr;
   int          err_total, checks;
   anp_sta_model anp_sta_model_inst (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
      .wr_out(wr), .rd_out(rd), .wdata_out(wd));
   anp_regs anp_regs_inst (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .pd_fault_evt_in(pd), .page_rx_evt_in(prx), .lp_np_able_in(lpnp),
      .lp_an_able_in(lpan), .toggle_in(tog), .partner_np_load_in(ld),
      .partner_np_in(pnp), .np_tx_out(nptx));
   initial
   begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rc(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] g;
      anp_sta_model_inst.rd_reg(a, g);
      chk(g, e);
   endtask
   task automatic t_exp();
      logic [15:0] g;
      {lpnp, lpan, pd, prx} = 4'hf;
      @(negedge clk_in);
      {pd, prx} = 2'b00;
      rc(5'h06, 16'h001f);
      rc(5'h06, 16'h000d);
      {lpnp, lpan} = 2'b00;
      fork
         anp_sta_model_inst.rd_reg(5'h06, g);
         begin
            @(negedge clk_in);
            {pd, prx} = 2'b11;
            @(negedge clk_in);
            {pd, prx} = 2'b00;
         end
      join
      chk(g, 16'h0004);
      rc(5'h06, 16'h0016);
      rc(5'h06, 16'h0004);
      $display("test expansion done");
   endtask
   task automatic t_np();
      anp_sta_model_inst.wr_reg(5'h07, 16'hffff);
      rc(5'h07, 16'hb7ff);
      tog = 1'b1;
      #1 chk(nptx, 16'hbfff);
      rc(5'h07, 16'hbfff);
      tog = 1'b0;
      anp_sta_model_inst.wr_reg(5'h07, 16'h2aaa);
      rc(5'h07, 16'h22aa);
      anp_sta_model_inst.wr_reg(5'h06, 16'hffff);
      anp_sta_model_inst.wr_reg(5'h08, 16'hffff);
      rc(5'h06, 16'h0004);
      rc(5'h08, 16'h0000);
      rc(5'h1f, 16'h0000);
      $display("test transmit page done");
   endtask
   task automatic t_lp();
      logic [15:0] g;
      {ld, pnp} = {1'b1, 16'hffff};
      @(negedge clk_in);
      ld = 1'b0;
      rc(5'h08, 16'hbfff);
      // capture followed at once by a read of the partner page
      {ld, pnp} = {1'b1, 16'h6c93};
      fork
         anp_sta_model_inst.rd_reg(5'h08, g);
         begin
            @(negedge clk_in);
            ld = 1'b0;
         end
      join
      chk(g, 16'h2c93);
      srst_in = 1'b1;
      @(negedge clk_in);
      srst_in = 1'b0;
      rc(5'h08, 16'h0000);
      rc(5'h07, 16'h2001);
      chk(nptx, 16'h2001);
      $display("test partner page done");
   endtask
   task automatic t_reset();
      repeat (3) @(negedge clk_in);
      srst_in = 1'b0;
      rc(5'h06, 16'h0004);
      rc(5'h07, 16'h2001);
      rc(5'h08, 16'h0000);
      $display("test reset done");
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      {srst_in, pd, prx, lpnp, lpan, tog, ld, pnp} = {7'h40, 16'h0000};
      t_reset();
      t_exp();
      t_np();
      t_lp();
      complete_run();
   end
endmodule // anp_regs_tb
`default_nettype wire
